/* include/phy_ctrl_map.vh */
`ifndef PHY_CTRL_MAP_VH
`define PHY_CTRL_MAP_VH

// ----------------------------------------------------------------
// Register offset and bit positions
// ----------------------------------------------------------------
`define BASIC_CONTROL_ADDR 5'h00
`define BIT_RESET          15
`define BIT_LOOPBACK       14
`define BIT_RATE           13
`define BIT_AN_ENABLE      12
`define BIT_LOW_POWER      11
`define BIT_ISOLATE        10
`define BIT_AN_RESTART     9
`define BIT_DUPLEX         8
`define BIT_COL_TEST       7
`define RESERVED_MASK      16'h007F

// ----------------------------------------------------------------
// Reset values (isolate bit added from address strap)
// ----------------------------------------------------------------
`define CTRL_RESET_VALUE   16'h3000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SOFT_RESET_CYCLES  16
`define COL_ASSERT_BITS    512
`define COL_DEASSERT_BITS  4
`define LOOP_DELAY_BITS    512
`define COL_DELAY_CYCLES   2

`endif

/* design/delay_line.v */
`include "phy_ctrl_map.vh"

// ----------------------------------------------------------------
// Fixed pipeline delay of a bus, reset to zero
// ----------------------------------------------------------------
module delay_line #(
  parameter WIDTH = 1,
  parameter DEPTH = 2
) (
  input  wire             core_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  reg [WIDTH*DEPTH-1:0] pipe_ff;

  always @(posedge core_clk) begin
    if (rst) begin
      pipe_ff <= {WIDTH*DEPTH{1'b0}};
    end else if (DEPTH > 1) begin
      pipe_ff <= {pipe_ff[WIDTH*(DEPTH-1)-1:0], din};
    end else begin
      pipe_ff <= din;
    end
  end

  assign dout = pipe_ff[WIDTH*DEPTH-1 -: WIDTH];

endmodule // delay_line

/* design/reset_sequencer.v */
`include "phy_ctrl_map.vh"

// ----------------------------------------------------------------
// Software reset duration counter
// ----------------------------------------------------------------
module reset_sequencer #(
  parameter CYCLES = `SOFT_RESET_CYCLES
) (
  input  wire core_clk,
  input  wire rst,
  input  wire start,
  output wire busy
);

  // Sized copy of the count so the load does not depend on a parameter part-select
  localparam [15:0] CYCLES_W = CYCLES;

  reg [15:0] count_ff;
  reg        busy_ff;

  always @(posedge core_clk) begin
    if (rst) begin
      count_ff <= 16'h0000;
      busy_ff  <= 1'b0;
    end else if (start && !busy_ff) begin
      count_ff <= CYCLES_W;
      busy_ff  <= 1'b1;
    end else if (busy_ff) begin
      if (count_ff <= 16'h0001) begin
        busy_ff <= 1'b0;
      end
      count_ff <= count_ff - 16'h0001;
    end
  end

  assign busy = busy_ff;

endmodule // reset_sequencer

/* design/phy_basic_control_register.v */
// Functional notes
// - Reset bit write resets registers and machines
// - Reset bit stays one, accesses blocked; the code drops writes but still answers reads
// - Loopback disables line, loops transmit to receive
// - Loopback receive valid within 512 bit times
// - Collision test keeps collision active in loopback
// - Hardware mode takes rate from strap
// - Software mode: autoneg result or rate bit
// - Hardware mode takes autoneg from strap
// - Autoneg enabled ignores rate and duplex bits
// - Low power: outputs low, line tristated
// - Low power keeps registers, clears sticky status
// - Isolate: MAC outputs high-z, inputs ignored
// - Isolate default one for address zero
// - Restart ignored while autoneg disabled
// - Restart self-clears once negotiation begins
// - Reserved bits read zero, writes ignored
// - Duplex from strap, bit, or autoneg
// - Collision test: COL follows transmit enable
`include "phy_ctrl_map.vh"

module phy_basic_control_register #(
  parameter RESET_CYCLES = `SOFT_RESET_CYCLES
) (
  input  wire        core_clk,
  input  wire        rst,
  // Management access (one-cycle strobes)
  input  wire [4:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  output wire        reg_busy,
  // Straps
  input  wire [4:0]  phy_address,
  input  wire        config_source_pin,
  input  wire        rate_strap_pin,
  input  wire        autoneg_strap_pin,
  input  wire        duplex_strap_pin,
  // Autoneg engine
  input  wire        an_result_rate,
  input  wire        an_result_duplex,
  input  wire        an_started,
  output wire        an_enable,
  output wire        an_restart,
  // Status sticky bits cleared on low-power entry or software reset
  output wire        sticky_status_clear,
  output wire        soft_reset_active,
  // Resolved operating mode
  output wire        speed_100,
  output wire        full_duplex,
  // MAC side
  input  wire        mac_tx_en,
  input  wire [3:0]  mac_txd,
  input  wire        mac_tx_er,
  input  wire        line_rx_dv,
  input  wire [3:0]  line_rxd,
  input  wire        line_rx_er,
  input  wire        line_col,
  input  wire        line_crs,
  output wire        mac_rx_dv,
  output wire [3:0]  mac_rxd,
  output wire        mac_rx_er,
  output wire        mac_col,
  output wire        mac_crs,
  output wire        mac_out_en,
  // Line side
  output wire        line_tx_en,
  output wire [3:0]  line_txd,
  output wire        line_tx_er,
  output wire        line_rx_enable,
  output wire        line_col_enable,
  output wire        line_driver_tristate
);

  reg        loopback_ff;
  reg        rate_ff;
  reg        an_en_ff;
  reg        low_power_ff;
  reg        isolate_ff;
  reg        restart_ff;
  reg        duplex_ff;
  reg        col_test_ff;
  reg        reset_req_ff;
  reg        low_power_d_ff;
  reg        col_out_ff;
  reg        mac_rx_dv_ff;
  reg [3:0]  mac_rxd_ff;
  reg        mac_rx_er_ff;
  reg        mac_crs_ff;
  wire       busy;
  wire       hw_mode;
  wire       an_active;
  wire       sel;
  wire       col_tx_d;
  wire       tx_gated;
  wire       iso_eff;
  wire [15:0] ctrl_word;

  // ----------------------------------------------------------------
  // Software reset
  // ----------------------------------------------------------------
  reset_sequencer #(
    .CYCLES (RESET_CYCLES)
  ) u_seq (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (reset_req_ff),
    .busy     (busy)
  );

  // Stretch the reset bit over the request cycle and the whole sequence
  assign soft_reset_active = reset_req_ff | busy;
  assign reg_busy          = soft_reset_active;
  assign sel               = (reg_addr == `BASIC_CONTROL_ADDR);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      reset_req_ff <= 1'b0;
      loopback_ff  <= 1'b0;
      rate_ff      <= 1'b1;
      an_en_ff     <= 1'b1;
      low_power_ff <= 1'b0;
      isolate_ff   <= (phy_address == 5'h00);
      restart_ff   <= 1'b0;
      duplex_ff    <= 1'b0;
      col_test_ff  <= 1'b0;
    end else if (soft_reset_active) begin
      // Defaults reloaded and writes dropped while reset runs
      reset_req_ff <= 1'b0;
      loopback_ff  <= 1'b0;
      rate_ff      <= 1'b1;
      an_en_ff     <= 1'b1;
      low_power_ff <= 1'b0;
      isolate_ff   <= (phy_address == 5'h00);
      restart_ff   <= 1'b0;
      duplex_ff    <= 1'b0;
      col_test_ff  <= 1'b0;
    end else if (reg_wr && sel) begin
      reset_req_ff <= reg_wdata[`BIT_RESET];
      loopback_ff  <= reg_wdata[`BIT_LOOPBACK];
      rate_ff      <= reg_wdata[`BIT_RATE];
      an_en_ff     <= reg_wdata[`BIT_AN_ENABLE];
      low_power_ff <= reg_wdata[`BIT_LOW_POWER];
      isolate_ff   <= reg_wdata[`BIT_ISOLATE];
      // A restart needs autoneg enabled by this same write
      restart_ff   <= restart_ff | (reg_wdata[`BIT_AN_RESTART] &
                      reg_wdata[`BIT_AN_ENABLE]);
      duplex_ff    <= reg_wdata[`BIT_DUPLEX];
      col_test_ff  <= reg_wdata[`BIT_COL_TEST];
    end else if (an_started || !an_active) begin
      restart_ff   <= 1'b0;
    end
  end

  // Isolate default after hard reset needs the strap, sampled a cycle later
  reg strap_done_ff;
  always @(posedge core_clk) begin
    if (rst) begin
      strap_done_ff <= 1'b0;
    end else begin
      strap_done_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign ctrl_word = {soft_reset_active, loopback_ff, rate_ff, an_en_ff,
                      low_power_ff, iso_eff, restart_ff, duplex_ff,
                      col_test_ff, 7'h00};

  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd && sel) begin
      reg_rdata <= ctrl_word & ~`RESERVED_MASK;
    end else if (reg_rd) begin
      reg_rdata <= 16'h0000;
    end
  end

  // First cycle after hard reset follows the strap directly
  assign iso_eff = strap_done_ff ? isolate_ff : (phy_address == 5'h00);

  // ----------------------------------------------------------------
  // Mode resolution
  // ----------------------------------------------------------------
  assign hw_mode     = ~config_source_pin;
  assign an_active   = hw_mode ? autoneg_strap_pin : an_en_ff;
  assign an_enable   = an_active & ~low_power_ff & ~soft_reset_active;
  assign an_restart  = restart_ff;
  // Strap in hardware mode; autoneg result or bits in software mode
  assign speed_100   = hw_mode ? rate_strap_pin :
                       (an_en_ff ? an_result_rate : rate_ff);
  assign full_duplex = hw_mode ? duplex_strap_pin :
                       (an_en_ff ? an_result_duplex : duplex_ff);

  // ----------------------------------------------------------------
  // Low power
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      low_power_d_ff <= 1'b0;
    end else begin
      low_power_d_ff <= low_power_ff;
    end
  end

  // Pulse on entry so status history does not survive power-down
  assign sticky_status_clear  = (low_power_ff & ~low_power_d_ff)
                              | soft_reset_active;
  assign line_driver_tristate = low_power_ff | loopback_ff;

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  // Inputs from the MAC are ignored while isolated or powered down
  assign tx_gated   = mac_tx_en & ~iso_eff & ~low_power_ff;
  assign line_tx_en = tx_gated & ~loopback_ff;
  assign line_txd   = (tx_gated & ~loopback_ff) ? mac_txd : 4'h0;
  assign line_tx_er = tx_gated & ~loopback_ff & mac_tx_er;
  assign line_rx_enable  = ~loopback_ff & ~low_power_ff;
  assign line_col_enable = (~loopback_ff | col_test_ff) & ~low_power_ff;

  // Collision test echo: short pipeline well inside 512 and 4 bit times
  delay_line #(
    .WIDTH (1),
    .DEPTH (`COL_DELAY_CYCLES)
  ) u_col_delay (
    .core_clk (core_clk),
    .rst      (rst),
    .din      (tx_gated),
    .dout     (col_tx_d)
  );

  always @(posedge core_clk) begin
    if (rst || low_power_ff) begin
      mac_rx_dv_ff <= 1'b0;
      mac_rxd_ff   <= 4'h0;
      mac_rx_er_ff <= 1'b0;
      mac_crs_ff   <= 1'b0;
      col_out_ff   <= 1'b0;
    end else if (loopback_ff) begin
      // Loop returns one cycle after transmit, under 512 bit times
      mac_rx_dv_ff <= tx_gated;
      mac_rxd_ff   <= mac_txd;
      mac_rx_er_ff <= tx_gated & mac_tx_er;
      mac_crs_ff   <= tx_gated;
      col_out_ff   <= col_test_ff & col_tx_d;
    end else begin
      mac_rx_dv_ff <= line_rx_dv;
      mac_rxd_ff   <= line_rxd;
      mac_rx_er_ff <= line_rx_er;
      mac_crs_ff   <= line_crs;
      col_out_ff   <= col_test_ff ? col_tx_d : line_col;
    end
  end

  assign mac_rx_dv  = mac_rx_dv_ff;
  assign mac_rxd    = mac_rxd_ff;
  assign mac_rx_er  = mac_rx_er_ff;
  assign mac_col    = col_out_ff;
  assign mac_crs    = mac_crs_ff;
  // Output enable low means high impedance toward the MAC
  assign mac_out_en = ~iso_eff;

endmodule // phy_basic_control_register

/* verification/phy_far_model.sv */
// ----------------------------------------
// Autoneg engine and line partner
// ----------------------------------------
module phy_far_model (
  input  logic       core_clk,
  input  logic       rst,
  input  logic       slow,
  input  logic       an_restart,
  input  logic       line_rx_enable,
  input  logic       line_tx_en,
  input  logic [3:0] line_txd,
  output logic       an_started,
  output logic       line_rx_dv,
  output logic       line_rx_er,
  output logic       line_col,
  output logic       line_crs,
  output logic [3:0] line_rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_ff;
  logic [7:0] pat_ff;
  always @(posedge core_clk) begin
    pat_ff <= rst ? 8'hA5 : {pat_ff[6:0], ~pat_ff[7]};
    cnt_ff <= (rst || !an_restart) ? 4'h0 : cnt_ff + 4'h1;
  end
  // Negotiation begins after a short or a long pause
  assign an_started = an_restart && cnt_ff == (slow ? 4'h6 : 4'h2);
  // A deaf receiver still sees line noise, so stale or gated data shows up
  assign line_rx_dv = line_rx_enable ? line_tx_en : pat_ff[0];
  assign line_rxd   = line_rx_enable ? line_txd : pat_ff[4:1];
  assign line_rx_er = line_rx_enable ? 1'b0 : pat_ff[7];
  assign line_col   = pat_ff[5];
  assign line_crs   = pat_ff[6];
endmodule // phy_far_model

/* verification/phy_ctrl_checker.sv */
// ----------------------------------------
// Port checker
// ----------------------------------------
module phy_ctrl_checker #(parameter int RESET_CYCLES = 2) (
  input logic        core_clk,
  input logic        rst,
  input logic [4:0]  reg_addr,
  input logic        reg_wr,
  input logic [15:0] reg_wdata,
  input logic [15:0] reg_rdata,
  input logic        reg_busy,
  input logic        soft_reset_active,
  input logic        config_source_pin,
  input logic        rate_strap_pin,
  input logic        autoneg_strap_pin,
  input logic        an_enable,
  input logic        an_result_rate,
  input logic        speed_100,
  input logic        an_restart,
  input logic        an_started,
  input logic        mac_out_en,
  input logic        line_tx_en,
  input logic        line_rx_enable,
  input logic        line_col_enable,
  input logic        mac_tx_en,
  input logic        mac_col
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] busy_len_ff;
  always @(posedge core_clk) busy_len_ff <= (rst || !reg_busy) ? 8'h00 : busy_len_ff + 8'h01;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reset_start: assert property (
    reg_wr && reg_addr == 5'h00 && reg_wdata[15] && !reg_busy |=> soft_reset_active && reg_busy)
    else $error("soft reset did not start");
  a_busy_len: assert property (
    $fell(reg_busy) |-> busy_len_ff == RESET_CYCLES + 1) else $error("busy length wrong");
  a_rsvd_zero: assert property (
    reg_rdata[6:0] == 7'h00) else $error("reserved bits not zero");
  a_hw_rate: assert property (
    !config_source_pin |-> speed_100 == rate_strap_pin) else $error("strap rate ignored");
  a_hw_autoneg: assert property (
    !config_source_pin && line_rx_enable && !soft_reset_active |-> an_enable == autoneg_strap_pin)
    else $error("strap autoneg ignored");
  a_an_rate: assert property (
    config_source_pin && an_enable |-> speed_100 == an_result_rate) else $error("rate not negotiated");
  a_restart_gate: assert property (
    $rose(an_restart) |-> an_enable) else $error("restart set with autoneg off");
  a_restart_clear: assert property (
    an_restart && an_started |=> !an_restart) else $error("restart did not clear");
  a_iso_tx: assert property (
    !mac_out_en |-> !line_tx_en) else $error("transmit passed while isolated");
  a_col_rise: assert property (
    line_col_enable && !line_rx_enable && $rose(mac_tx_en) |-> ##[1:128] mac_col)
    else $error("collision test late");
  a_col_fall: assert property (
    line_col_enable && !line_rx_enable && $fell(mac_tx_en) |-> ##[1:4] !mac_col)
    else $error("collision test did not drop");
endmodule // phy_ctrl_checker
bind phy_basic_control_register phy_ctrl_checker #(.RESET_CYCLES(RESET_CYCLES)) i_phy_ctrl_checker (.*);

/* verification/phy_basic_control_register_tb.sv */
module phy_basic_control_register_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, config_source_pin = 1, slow = 0;
  logic rate_strap_pin = 0, autoneg_strap_pin = 0, duplex_strap_pin = 0, an_result_rate = 0;
  logic an_result_duplex = 0, mac_tx_en = 0, mac_tx_er = 0, rd_d = 0;
  logic [4:0]  reg_addr = 5'h00, phy_address = 5'h00;
  logic [3:0]  mac_txd = 4'h0, line_rxd, mac_rxd, line_txd;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, w;
  logic reg_busy, an_started, an_enable, an_restart, sticky_status_clear, soft_reset_active;
  logic speed_100, full_duplex, line_rx_dv, line_rx_er, line_col, line_crs, mac_rx_dv;
  logic mac_rx_er, mac_col, mac_crs, mac_out_en, line_tx_en, line_tx_er, line_rx_enable;
  logic line_col_enable, line_driver_tristate;
  logic [15:0] exp_q[$];
  int n_mismatch = 0, check_count = 0, seed = 32'h736d;
  wire [3:0] mon = {mac_col, mac_rx_dv, an_restart, reg_busy};
  phy_basic_control_register #(.RESET_CYCLES(2)) i_phy_basic_control_register (.*);
  phy_far_model i_phy_far_model (.*);
  initial forever #20 core_clk = ~core_clk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk_word(input logic [15:0] e, input logic [15:0] a);
    check_count++;
    if (e !== a) begin
      n_mismatch++;
      $display("unexpected t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic chk_bit(input logic e, ref logic a);
    @(negedge core_clk);
    chk_word({15'h0000, e}, {15'h0000, a});
  endtask
  task wr(input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= 5'h00;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  task drv_tx(input logic v);
    @(posedge core_clk);
    mac_tx_en <= v;
  endtask
  // Bounded wait; running out ends the run
  task wait_lvl(input int i, input logic v, input int lim);
    int n;
    n = 0;
    @(negedge core_clk);
    while (mon[i] !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk_word({15'h0000, v}, {15'h0000, mon[i]});
    if (mon[i] !== v) test_done;
  endtask
  always @(posedge core_clk) rd_d <= reg_rd && !reg_busy;
  always @(negedge core_clk) if (rd_d) chk_word(exp_q.pop_front(), reg_rdata);
  initial begin
    #2000000;
    n_mismatch++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    wr(16'h8000);
    wr(16'h0100);
    wait_lvl(0, 1'b0, 20);
    rd(5'h00, 16'h3400);
    chk_bit(1'b0, mac_out_en);
    @(posedge core_clk);
    phy_address <= 5'h03;
    wr(16'h8000);
    wait_lvl(0, 1'b0, 20);
    rd(5'h00, 16'h3000);
    rd(5'h01, 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      w = 16'($random(seed));
      @(posedge core_clk);
      {an_result_rate, an_result_duplex} <= w[1:0];
      w = w & 16'h3D80;
      wr(w);
      rd(5'h00, w);
      chk_bit(w[12] ? an_result_rate : w[13], speed_100);
      chk_bit(w[12] ? an_result_duplex : w[8], full_duplex);
      @(posedge core_clk);
      {config_source_pin, rate_strap_pin, autoneg_strap_pin, duplex_strap_pin} <=
        {1'b0, ~w[13], w[8], ~w[12]};
      chk_bit(~w[13], speed_100);
      chk_bit(w[8] & ~w[11], an_enable);
      chk_bit(~w[12], full_duplex);
      @(posedge core_clk);
      config_source_pin <= 1'b1;
    end
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      wr(16'h1200);
      wait_lvl(1, 1'b1, 4);
      wait_lvl(1, 1'b0, 12);
    end
    wr(16'h0200);
    rd(5'h00, 16'h0000);
    $display("autoneg test done");
    wr(16'h4000);
    chk_bit(1'b1, line_driver_tristate);
    chk_bit(1'b0, line_rx_enable);
    chk_bit(1'b0, line_col_enable);
    @(posedge core_clk);
    mac_txd <= 4'hA;
    mac_tx_en <= 1'b1;
    wait_lvl(2, 1'b1, 127);
    chk_word(16'h000A, {12'h000, mac_rxd});
    drv_tx(1'b0);
    wr(16'h4080);
    chk_bit(1'b1, line_col_enable);
    drv_tx(1'b1);
    wait_lvl(3, 1'b1, 127);
    drv_tx(1'b0);
    wait_lvl(3, 1'b0, 4);
    $display("loopback test done");
    wr(16'h0800);
    chk_bit(1'b1, sticky_status_clear);
    chk_bit(1'b1, line_driver_tristate);
    chk_word(16'h0000, {8'h00, mac_rx_dv, mac_rx_er, mac_col, mac_crs, mac_rxd});
    rd(5'h00, 16'h0800);
    wr(16'h0400);
    drv_tx(1'b1);
    chk_bit(1'b0, mac_out_en);
    chk_bit(1'b0, line_tx_en);
    $display("isolate test done");
    test_done;
  end
endmodule // phy_basic_control_register_tb
